// File: gdsp_pkg.sv
package gdsp_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_SUPPLY = 8'h00;
  localparam logic [7:0] OFF_PUMP = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_STATE = 8'h10;

  // register select codes
  localparam logic [2:0] SEL_SUPPLY = 3'h0;
  localparam logic [2:0] SEL_PUMP = 3'h1;
  localparam logic [2:0] SEL_STATUS = 3'h2;
  localparam logic [2:0] SEL_MASK = 3'h3;
  localparam logic [2:0] SEL_STATE = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // supply config: [1:0] drive voltage select, [2] low rail precharge enable
  localparam int SUP_PRE_BIT = 2;
  // pump config: [1:0] pump clock select, [2] spread spectrum enable
  localparam int PUMP_SPREAD_BIT = 2;
  localparam logic [2:0] SUPPLY_RST = 3'h0;
  localparam logic [2:0] PUMP_RST = 3'h0;

  // interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_LS = 0;
  localparam int IRQ_HS = 1;
  localparam int IRQ_PC = 2;
  localparam logic [2:0] MASK_RST = 3'h0;

  // drive voltage select encoding
  localparam logic [1:0] VSEL_7V = 2'h3;
  localparam logic [1:0] VSEL_10V = 2'h2;
  localparam logic [1:0] VSEL_12V = 2'h0;
  localparam logic [1:0] VSEL_15V = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int NCH = 6;

  // pump clock half periods in mclk cycles (100 MHz)
  localparam logic [7:0] PUMP_HALF_0 = 8'h28;
  localparam logic [7:0] PUMP_HALF_1 = 8'h14;
  localparam logic [7:0] PUMP_HALF_2 = 8'h0A;
  localparam logic [7:0] PUMP_HALF_3 = 8'h06;
  // spread: deviation in cycles, half periods per deviation step
  localparam logic [7:0] SPREAD_DEV = 8'h02;
  localparam logic [7:0] SPREAD_STEP = 8'h04;

  // drive voltage in volts as a hex number
  function automatic logic [3:0] drive_volts(input logic [1:0] vsel);
    case (vsel)
      VSEL_7V: drive_volts = 4'h7;
      VSEL_10V: drive_volts = 4'hA;
      VSEL_15V: drive_volts = 4'hF;
      default: drive_volts = 4'hC;
    endcase
  endfunction : drive_volts
endpackage : gdsp_pkg

// File: gdsp_pump_clk.sv
`timescale 1ns/10ps
module gdsp_pump_clk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] clk_sel,
  input wire logic spread_en,
  output logic pump_clk
);
  typedef struct packed {
    logic clk;
    logic [7:0] cnt;
    logic [7:0] dev;
    logic dir;
    logic [7:0] step;
  } gdsp_pump_s;

  gdsp_pump_s st;
  gdsp_pump_s next_st;
  logic [7:0] base;
  logic [7:0] limit;

  function automatic logic [7:0] half_of(input logic [1:0] sel);
    case (sel)
      2'h0: half_of = gdsp_pkg::PUMP_HALF_0;
      2'h1: half_of = gdsp_pkg::PUMP_HALF_1;
      2'h2: half_of = gdsp_pkg::PUMP_HALF_2;
      default: half_of = gdsp_pkg::PUMP_HALF_3;
    endcase
  endfunction : half_of

  always_comb begin
    next_st = st;
    base = half_of(clk_sel);
    limit = 8'(base - gdsp_pkg::SPREAD_DEV + st.dev);
    next_st.cnt = 8'(st.cnt + 8'h01);
    if (next_st.cnt >= limit) begin
      next_st.cnt = 8'h00;
      next_st.clk = !st.clk;
      if (spread_en) begin
        next_st.step = 8'(st.step + 8'h01);
        if (st.step == 8'(gdsp_pkg::SPREAD_STEP - 8'h01)) begin
          next_st.step = 8'h00;
          if (st.dir) begin
            next_st.dev = 8'(st.dev - 8'h01);
            if (st.dev == 8'h01) begin
              next_st.dir = 1'b0;
            end
          end else begin
            next_st.dev = 8'(st.dev + 8'h01);
            if (st.dev == 8'(2 * gdsp_pkg::SPREAD_DEV - 1)) begin
              next_st.dir = 1'b1;
            end
          end
        end
      end
    end
    if (!spread_en) begin
      next_st.dev = gdsp_pkg::SPREAD_DEV;
      next_st.dir = 1'b0;
      next_st.step = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '{clk: 1'b0, cnt: 8'h00, dev: gdsp_pkg::SPREAD_DEV, dir: 1'b0, step: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign pump_clk = st.clk;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_spread_bound: assert property (st.dev <= 8'(2 * gdsp_pkg::SPREAD_DEV)) else $error("spread out of range");
  a_nominal_hold: assert property (!spread_en |=> st.dev == gdsp_pkg::SPREAD_DEV) else $error("nominal lost");
endmodule : gdsp_pump_clk

// File: gdsp_precharge.sv
`timescale 1ns/10ps
module gdsp_precharge (
  input wire logic mclk,
  input wire logic rst,
  input wire logic precharge_enable,
  input wire logic driver_enable_pin,
  input wire logic rail_near_buck,
  output logic precharging,
  output logic done,
  output logic done_pulse
);
  typedef enum logic [1:0] {PC_IDLE, PC_CHARGE, PC_HOLD, PC_SPENT} gdsp_pc_e;
  typedef struct packed {
    gdsp_pc_e state;
    logic pulse;
    logic charging;
  } gdsp_pc_s;

  gdsp_pc_s st;
  gdsp_pc_s next_st;

  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    case (st.state)
      PC_IDLE: begin
        if (driver_enable_pin) begin
          next_st.state = PC_SPENT;
          next_st.pulse = 1'b1;
        end else if (precharge_enable) begin
          next_st.state = PC_CHARGE;
        end
      end
      PC_CHARGE, PC_HOLD: begin
        if (driver_enable_pin) begin
          next_st.state = PC_SPENT;
          next_st.pulse = 1'b1;
        end else if (!precharge_enable) begin
          next_st.state = PC_IDLE;
        end else if (rail_near_buck) begin
          next_st.state = PC_HOLD;
        end
      end
      PC_SPENT: begin
        next_st.state = PC_SPENT;
      end
      default: begin
        next_st.state = PC_IDLE;
      end
    endcase
    // registered so the top output comes straight from a flop
    next_st.charging = (next_st.state == PC_CHARGE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '{state: PC_IDLE, pulse: 1'b0, charging: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign precharging = st.charging;
  assign done = (st.state == PC_SPENT);
  assign done_pulse = st.pulse;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_pc_once: assert property (st.state == PC_SPENT |=> st.state == PC_SPENT) else $error("precharge rearmed");
  a_pc_stop_en: assert property (driver_enable_pin |=> !precharging) else $error("precharge after enable");
endmodule : gdsp_precharge

// File: gdsp_ctrl.sv
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - one drive voltage for both pumps
// - select codes 11=7V 10=10V 00=12V 01=15V
// - pump clock select picks four frequencies
// - spread spectrum wobbles pump clock, else nominal
// - precharge low rail before driver enable
// - precharge only on first enable after power-up
// - low rail lockout blocks PWM until rising
// - low rail fall: stop PWM, hi-z, fault
// - low rail fault pulls fault line low
// - high rail lockout held until rising threshold
// - high rail fall: hi-z and fault
// - high rail fault pulls fault line low
// - weak gate pull-down always on
// - strong pull-down on rising gate when off
module gdsp_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic driver_enable_pin,
  input wire logic [5:0] pwm_in,
  input wire logic [5:0] vgs_rising,
  input wire logic ls_rail_above_rise,
  input wire logic ls_rail_below_fall,
  input wire logic hs_rail_above_rise,
  input wire logic hs_rail_below_fall,
  input wire logic ls_rail_near_buck,
  output logic [5:0] gate_drive,
  output logic [5:0] gate_oe,
  output logic [5:0] strong_pd,
  output logic [5:0] weak_pd,
  output logic fault_out_n,
  output logic irq,
  output logic [1:0] ls_pump_vsel,
  output logic [1:0] hs_pump_vsel,
  output logic pump_enable,
  output logic precharge_active,
  output logic pump_clk
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] supply;
    logic [2:0] pump;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic ls_lock;
    logic hs_lock;
    logic ls_flt;
    logic hs_flt;
    logic fault_n;
    logic irq;
    logic [5:0] gate_drive;
    logic [5:0] gate_oe;
    logic [5:0] strong_pd;
    logic [5:0] weak_pd;
    logic [1:0] ls_vsel;
    logic [1:0] hs_vsel;
    logic pump_en;
  } gdsp_ctrl_s;

  gdsp_ctrl_s st;
  gdsp_ctrl_s next_st;
  logic active_c;
  logic [5:0] g_drive;
  logic [5:0] g_strong;
  logic pc_done;
  logic pc_pulse;
  logic [2:0] rsel;
  logic [2:0] wsel;
  logic [2:0] events;
  logic rd_clear;

  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      gdsp_pkg::OFF_SUPPLY: reg_sel = gdsp_pkg::SEL_SUPPLY;
      gdsp_pkg::OFF_PUMP: reg_sel = gdsp_pkg::SEL_PUMP;
      gdsp_pkg::OFF_IRQ_STATUS: reg_sel = gdsp_pkg::SEL_STATUS;
      gdsp_pkg::OFF_IRQ_MASK: reg_sel = gdsp_pkg::SEL_MASK;
      gdsp_pkg::OFF_STATE: reg_sel = gdsp_pkg::SEL_STATE;
      default: reg_sel = gdsp_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // driver runs only when enabled and both rails are out of lockout
  assign active_c = driver_enable_pin && !st.ls_lock && !st.hs_lock;

  for (genvar i = 0; i < gdsp_pkg::NCH; i++) begin : g_ch
    assign g_drive[i] = active_c & pwm_in[i];
    assign g_strong[i] = !active_c & vgs_rising[i];
  end

  always_comb begin
    next_st = st;
    rsel = reg_sel(s_axi_araddr);
    wsel = reg_sel(st.aw_addr);
    rd_clear = 1'b0;
    // write channel
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (wsel == gdsp_pkg::SEL_NONE) ? gdsp_pkg::RESP_SLVERR : gdsp_pkg::RESP_OKAY;
      if (st.w_strb[0]) begin
        case (wsel)
          gdsp_pkg::SEL_SUPPLY: next_st.supply = st.w_data[2:0];
          gdsp_pkg::SEL_PUMP: next_st.pump = st.w_data[2:0];
          gdsp_pkg::SEL_MASK: next_st.irq_mask = st.w_data[2:0];
          default: next_st.supply = st.supply;
        endcase
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    // read channel
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = gdsp_pkg::RESP_OKAY;
      case (rsel)
        gdsp_pkg::SEL_SUPPLY: next_st.rdata = {29'h0, st.supply};
        gdsp_pkg::SEL_PUMP: next_st.rdata = {29'h0, st.pump};
        gdsp_pkg::SEL_STATUS: begin
          next_st.rdata = {29'h0, st.irq_status};
          rd_clear = 1'b1;
        end
        gdsp_pkg::SEL_MASK: next_st.rdata = {29'h0, st.irq_mask};
        gdsp_pkg::SEL_STATE: next_st.rdata = {20'h0, gdsp_pkg::drive_volts(st.supply[1:0]), 2'h0,
          !st.fault_n, precharge_active, pc_done, active_c, st.hs_lock, st.ls_lock};
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = gdsp_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    // low rail lockout, fault on falling threshold
    if (ls_rail_below_fall) begin
      next_st.ls_lock = 1'b1;
      if (!st.ls_lock) begin
        next_st.ls_flt = 1'b1;
      end
    end else if (ls_rail_above_rise) begin
      next_st.ls_lock = 1'b0;
      next_st.ls_flt = 1'b0;
    end
    // high rail lockout, held from reset until rising threshold
    if (hs_rail_below_fall) begin
      next_st.hs_lock = 1'b1;
      if (!st.hs_lock) begin
        next_st.hs_flt = 1'b1;
      end
    end else if (hs_rail_above_rise) begin
      next_st.hs_lock = 1'b0;
      next_st.hs_flt = 1'b0;
    end
    events = 3'h0;
    events[gdsp_pkg::IRQ_LS] = ls_rail_below_fall && !st.ls_lock;
    events[gdsp_pkg::IRQ_HS] = hs_rail_below_fall && !st.hs_lock;
    events[gdsp_pkg::IRQ_PC] = pc_pulse;
    // new event wins over the read clear
    next_st.irq_status = (rd_clear ? 3'h0 : st.irq_status) | events;
    next_st.irq = |(st.irq_status & st.irq_mask);
    next_st.fault_n = !(st.ls_flt || st.hs_flt);
    next_st.gate_drive = g_drive;
    next_st.gate_oe = {gdsp_pkg::NCH{active_c}};
    next_st.strong_pd = g_strong;
    next_st.weak_pd = '1;
    next_st.ls_vsel = st.supply[1:0];
    next_st.hs_vsel = st.supply[1:0];
    next_st.pump_en = driver_enable_pin;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.supply <= gdsp_pkg::SUPPLY_RST;
      st.pump <= gdsp_pkg::PUMP_RST;
      st.irq_mask <= gdsp_pkg::MASK_RST;
      st.ls_lock <= 1'b1;
      st.hs_lock <= 1'b1;
      st.fault_n <= 1'b1;
      st.weak_pd <= '1;
    end else begin
      st <= next_st;
    end
  end

  gdsp_pump_clk u_pump_clk (
    .mclk(mclk),
    .rst(rst),
    .clk_sel(st.pump[1:0]),
    .spread_en(st.pump[gdsp_pkg::PUMP_SPREAD_BIT]),
    .pump_clk(pump_clk)
  );

  gdsp_precharge u_precharge (
    .mclk(mclk),
    .rst(rst),
    .precharge_enable(st.supply[gdsp_pkg::SUP_PRE_BIT]),
    .driver_enable_pin(driver_enable_pin),
    .rail_near_buck(ls_rail_near_buck),
    .precharging(precharge_active),
    .done(pc_done),
    .done_pulse(pc_pulse)
  );

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign gate_drive = st.gate_drive;
  assign gate_oe = st.gate_oe;
  assign strong_pd = st.strong_pd;
  assign weak_pd = st.weak_pd;
  assign fault_out_n = st.fault_n;
  assign irq = st.irq;
  assign ls_pump_vsel = st.ls_vsel;
  assign hs_pump_vsel = st.hs_vsel;
  assign pump_enable = st.pump_en;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ls_lock_block: assert property (st.ls_lock |=> gate_oe == 6'h00 && gate_drive == 6'h00) else $error("pwm in ls lock");
  a_ls_fall_hiz: assert property (ls_rail_below_fall |=> ##1 gate_oe == 6'h00) else $error("no hiz on ls fall");
  a_ls_fault_pin: assert property ($rose(st.ls_flt) |=> !fault_out_n) else $error("ls fault not shown");
  a_hs_lock_block: assert property (st.hs_lock |=> gate_oe == 6'h00) else $error("pwm in hs lock");
  a_hs_fall_hiz: assert property (hs_rail_below_fall |=> ##1 gate_oe == 6'h00) else $error("no hiz on hs fall");
  a_hs_fault_pin: assert property ($rose(st.hs_flt) |=> !fault_out_n) else $error("hs fault not shown");
  a_fault_release: assert property (!st.ls_flt && !st.hs_flt |=> fault_out_n) else $error("fault stuck");
  a_weak_pd_on: assert property (weak_pd == 6'h3F) else $error("weak pull-down off");
  a_strong_pd: assert property (!active_c && vgs_rising[0] |=> strong_pd[0]) else $error("no strong pd");
  a_vsel_equal: assert property (ls_pump_vsel == hs_pump_vsel) else $error("pump voltages differ");
  a_pwm_pass: assert property (active_c && pwm_in[3] |=> gate_drive[3] && gate_oe[3]) else $error("pwm lost");
  a_drive_in_oe: assert property ((gate_drive & ~gate_oe) == 6'h00) else $error("drive while hi-z");
  a_ls_flt_locked: assert property (st.ls_flt |-> st.ls_lock) else $error("ls fault unlocked");
  a_hs_flt_locked: assert property (st.hs_flt |-> st.hs_lock) else $error("hs fault unlocked");
  a_strong_idle: assert property (active_c |=> strong_pd == 6'h00) else $error("strong pd while driving");
  a_vsel_follow: assert property (ls_pump_vsel == $past(st.supply[1:0])) else $error("vsel not applied");
  a_pump_follow: assert property (driver_enable_pin |=> pump_enable) else $error("pump not enabled");
  // interrupt status and level
  a_event_wins: assert property (events[gdsp_pkg::IRQ_LS] |=> st.irq_status[gdsp_pkg::IRQ_LS]) else $error("event lost");
  a_status_sticky: assert property (st.irq_status[gdsp_pkg::IRQ_HS] && !rd_clear |=> st.irq_status[gdsp_pkg::IRQ_HS])
    else $error("status dropped");
  a_irq_level: assert property (|(st.irq_status & st.irq_mask) |=> irq) else $error("irq missing");
  c_ls_fault: cover property (!fault_out_n ##[1:20] fault_out_n);
  c_precharge: cover property (precharge_active ##[1:50] pc_done);
  c_irq: cover property (irq ##1 s_axi_rvalid);
  c_hs_fault: cover property (st.hs_flt ##2 !fault_out_n);
  c_pwm_run: cover property (gate_oe == 6'h3F && gate_drive != 6'h00);
endmodule : gdsp_ctrl

// File: gdsp_rail_model.sv
`timescale 1ns/10ps
module gdsp_rail_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] rail_ok,
  input wire logic precharge_active,
  output logic ls_rail_above_rise,
  output logic ls_rail_below_fall,
  output logic hs_rail_above_rise,
  output logic hs_rail_below_fall,
  output logic ls_rail_near_buck
);
  // rails ramp over four cycles when healthy and collapse at once under overload
  logic [2:0] lvl [2];
  logic [2:0] pre_cnt;
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst || !rail_ok[i]) begin
        lvl[i] <= 3'h0;
      end else if (lvl[i] != 3'h4) begin
        lvl[i] <= lvl[i] + 3'h1;
      end
    end
    // pre-charged rail stays near the buck level until reset, even while rail_ok is low
    if (rst) begin
      pre_cnt <= 3'h0;
    end else if (precharge_active && pre_cnt != 3'h3) begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end
  assign ls_rail_above_rise = lvl[0] == 3'h4;
  assign ls_rail_below_fall = lvl[0] == 3'h0;
  assign hs_rail_above_rise = lvl[1] == 3'h4;
  assign hs_rail_below_fall = lvl[1] == 3'h0;
  assign ls_rail_near_buck = pre_cnt == 3'h3;
endmodule : gdsp_rail_model

// File: gdsp_ctrl_test.sv
`timescale 1ns/10ps
module gdsp_ctrl_test;
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic driver_enable_pin = 1'b0;
  logic [5:0] pwm_in = 6'h00, vgs_rising = 6'h00;
  logic [1:0] rail_ok = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ls_pump_vsel, hs_pump_vsel;
  logic [31:0] s_axi_rdata;
  logic [5:0] gate_drive, gate_oe, strong_pd, weak_pd;
  logic fault_out_n, irq, pump_enable, precharge_active, pump_clk;
  logic ls_rail_above_rise, ls_rail_below_fall, hs_rail_above_rise, hs_rail_below_fall, ls_rail_near_buck;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic seen;
  int h, lo, hi;
  logic [7:0] hv [4] = '{gdsp_pkg::PUMP_HALF_0, gdsp_pkg::PUMP_HALF_1, gdsp_pkg::PUMP_HALF_2, gdsp_pkg::PUMP_HALF_3};
  logic [1:0] code [4] = '{gdsp_pkg::VSEL_7V, gdsp_pkg::VSEL_10V, gdsp_pkg::VSEL_12V, gdsp_pkg::VSEL_15V};
  logic [3:0] volts [4] = '{4'h7, 4'hA, 4'hC, 4'hF};

  gdsp_ctrl uut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .driver_enable_pin, .pwm_in,
    .vgs_rising, .ls_rail_above_rise, .ls_rail_below_fall, .hs_rail_above_rise, .hs_rail_below_fall,
    .ls_rail_near_buck, .gate_drive, .gate_oe, .strong_pd, .weak_pd, .fault_out_n, .irq, .ls_pump_vsel,
    .hs_pump_vsel, .pump_enable, .precharge_active, .pump_clk);
  gdsp_rail_model rails (.mclk, .rst, .rail_ok, .precharge_active, .ls_rail_above_rise, .ls_rail_below_fall,
    .hs_rail_above_rise, .hs_rail_below_fall, .ls_rail_near_buck);

  always #5 mclk = ~mclk;

  task results;
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdt

  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input string m);
    wr(a, d, rsp);
    chk(32'(rsp), 32'(er), m);
  endtask : wc

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string m);
    rdt(a, rd, rsp);
    chk(rd, e, m);
    chk(32'(rsp), 32'(er), m);
  endtask : rc

  // one pump clock half period, counted in mclk cycles
  task automatic half(output int n);
    logic p;
    p = pump_clk;
    do @(posedge mclk); while (pump_clk === p);
    p = pump_clk;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pump_clk === p && n < 200);
  endtask : half

  task automatic span(input int n);
    half(h);
    lo = 255;
    hi = 0;
    repeat (n) begin
      half(h);
      if (h < lo) lo = h;
      if (h > hi) hi = h;
    end
  endtask : span

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    chk(32'(weak_pd), 32'h3F, "weak pd");
    chk(32'(fault_out_n), 32'h1, "fault idle");
    chk(32'(gate_oe), 32'h0, "startup hi-z");
    rc(gdsp_pkg::OFF_SUPPLY, 32'h0, gdsp_pkg::RESP_OKAY, "supply rst");
    rc(gdsp_pkg::OFF_PUMP, 32'h0, gdsp_pkg::RESP_OKAY, "pump rst");
    rc(gdsp_pkg::OFF_IRQ_MASK, 32'h0, gdsp_pkg::RESP_OKAY, "mask rst");
    rc(gdsp_pkg::OFF_STATE, 32'h0C03, gdsp_pkg::RESP_OKAY, "state rst");
    wc(8'h20, 32'h5, gdsp_pkg::RESP_SLVERR, "unmapped wr");
    rc(8'h20, 32'h0, gdsp_pkg::RESP_SLVERR, "unmapped rd");
    wc(gdsp_pkg::OFF_IRQ_STATUS, 32'h7, gdsp_pkg::RESP_OKAY, "status wr");
    rc(gdsp_pkg::OFF_IRQ_STATUS, 32'h0, gdsp_pkg::RESP_OKAY, "status ro");
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wc(gdsp_pkg::OFF_SUPPLY, 32'(code[c]), gdsp_pkg::RESP_OKAY, "vsel wr");
      cyc(1);
      chk(32'(ls_pump_vsel), 32'(code[c]), "ls vsel");
      chk(32'(hs_pump_vsel), 32'(code[c]), "hs vsel");
      rdt(gdsp_pkg::OFF_STATE, rd, rsp);
      chk(32'(rd[11:8]), 32'(volts[c]), "volts");
    end
    $display("test drive voltage done");
    for (int s = 0; s < 4; s++) begin
      wc(gdsp_pkg::OFF_PUMP, 32'(s), gdsp_pkg::RESP_OKAY, "pump wr");
      span(4);
      chk(32'(lo), 32'(hv[s]), "pump half min");
      chk(32'(hi), 32'(hv[s]), "pump half max");
    end
    wc(gdsp_pkg::OFF_PUMP, 32'h7, gdsp_pkg::RESP_OKAY, "spread on");
    span(40);
    chk(32'(lo), 32'(gdsp_pkg::PUMP_HALF_3 - gdsp_pkg::SPREAD_DEV), "spread low");
    chk(32'(hi), 32'(gdsp_pkg::PUMP_HALF_3 + gdsp_pkg::SPREAD_DEV), "spread high");
    wc(gdsp_pkg::OFF_PUMP, 32'h3, gdsp_pkg::RESP_OKAY, "spread off");
    span(8);
    chk(32'(hi - lo), 32'h0, "nominal again");
    chk(32'(lo), 32'(gdsp_pkg::PUMP_HALF_3), "nominal half");
    $display("test pump clock done");
    wc(gdsp_pkg::OFF_IRQ_MASK, 32'h7, gdsp_pkg::RESP_OKAY, "mask all");
    wc(gdsp_pkg::OFF_SUPPLY, 32'(1 << gdsp_pkg::SUP_PRE_BIT), gdsp_pkg::RESP_OKAY, "pre on");
    seen = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      if (precharge_active === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'h1, "precharge ran");
    chk(32'(precharge_active), 32'h0, "precharge held");
    driver_enable_pin <= 1'b1;
    cyc(4);
    chk(32'(irq), 32'h1, "irq spent");
    rc(gdsp_pkg::OFF_IRQ_STATUS, 32'h4, gdsp_pkg::RESP_OKAY, "spent");
    cyc(2);
    chk(32'(irq), 32'h0, "irq cleared");
    chk(32'(gate_oe), 32'h0, "locked hi-z");
    chk(32'(fault_out_n), 32'h1, "startup no fault");
    driver_enable_pin <= 1'b0;
    seen = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      if (precharge_active !== 1'b0) seen = 1'b1;
    end
    chk(32'(seen), 32'h0, "no second precharge");
    driver_enable_pin <= 1'b1;
    rail_ok <= 2'b01;
    cyc(12);
    chk(32'(gate_oe), 32'h0, "hs lock holds");
    rail_ok <= 2'b11;
    pwm_in <= 6'h2A;
    cyc(12);
    chk(32'(gate_oe), 32'h3F, "driving");
    chk(32'(gate_drive), 32'h2A, "pwm passes");
    chk(32'(pump_enable), 32'h1, "pump on");
    $display("test precharge and startup done");
    wc(gdsp_pkg::OFF_IRQ_MASK, 32'h1, gdsp_pkg::RESP_OKAY, "mask ls");
    for (int k = 0; k < 2; k++) begin
      rail_ok <= 2'b11 ^ (2'b01 << k);
      cyc(6);
      chk(32'(gate_oe), 32'h0, "fall hi-z");
      chk(32'(gate_drive), 32'h0, "fall pwm stop");
      chk(32'(fault_out_n), 32'h0, "fall fault");
      chk(32'(irq), 32'(k == 0), "fall irq");
      rc(gdsp_pkg::OFF_IRQ_STATUS, 32'(1 << k), gdsp_pkg::RESP_OKAY, "fall status");
      cyc(2);
      chk(32'(irq), 32'h0, "irq read clear");
      chk(32'(fault_out_n), 32'h0, "fault held");
      rail_ok <= 2'b11;
      cyc(12);
      chk(32'(fault_out_n), 32'h1, "fault gone");
      chk(32'(gate_oe), 32'h3F, "drive again");
    end
    $display("test lockout done");
    vgs_rising <= 6'h15;
    cyc(4);
    chk(32'(strong_pd), 32'h0, "no strong on");
    driver_enable_pin <= 1'b0;
    cyc(4);
    chk(32'(strong_pd), 32'h15, "strong off");
    chk(32'(pump_enable), 32'h0, "pump off");
    chk(32'(weak_pd), 32'h3F, "weak off");
    chk(32'(gate_oe), 32'h0, "disabled hi-z");
    $display("test pull down done");
    results();
  end
endmodule : gdsp_ctrl_test
